// >>> hdl/pmt_defines.svh
// How it works
// - The 8-bit count climbs from zero to the period value, then goes back to zero on the next step.
// - Reset loads the period register with all ones.
// - Each period match feeds a 4-bit postscaler giving one event per 1 to 16 matches.
// - Every postscaler event sets the match interrupt flag.
// - Writing the count or control register, or any reset, clears prescaler and postscaler.
// - Writing the control register leaves the count as it was.
// - The count register is read/write and reset clears it to zero.
// - Control bit 2 runs the timer; while clear the count holds still.
// - Control reads bit 7 as zero, postscale select in bits 6..3, prescale select in bits 1..0.
// - Software may read and write the period register at any time.
// - The period match serves as the time base for the PWM of the capture/compare unit.
// - The match, taken ahead of the postscaler, goes out to the serial port for its shift clock.
`ifndef PMT_DEFINES_SVH
`define PMT_DEFINES_SVH

// Register byte offsets
`define PMT_OFF_COUNT 8'h00
`define PMT_OFF_PERIOD 8'h04
`define PMT_OFF_CONTROL 8'h08
`define PMT_OFF_FLAG 8'h0c

// Control and flag field positions
`define PMT_CTL_POST_HI 6
`define PMT_CTL_POST_LO 3
`define PMT_CTL_RUN 2
`define PMT_CTL_PRE_HI 1
`define PMT_CTL_PRE_LO 0
`define PMT_FLAG_BIT 0

// Reset values
`define PMT_RST_COUNT 8'h00
`define PMT_RST_PERIOD 8'hff
`define PMT_RST_CONTROL 8'h00

// Divider terminal counts
`define PMT_QUARTER_LIMIT 4'h3
`define PMT_PRE1_LIMIT 4'h0
`define PMT_PRE4_LIMIT 4'h3
`define PMT_PRE16_LIMIT 4'hf

`endif

// >>> hdl/pmt_pkg.sv
package pmt_pkg;

  typedef logic [7:0] pmt_byte_t;

  typedef enum logic [1:0] {
    PMT_PRE_1 = 2'b00,
    PMT_PRE_4 = 2'b01,
    PMT_PRE_16 = 2'b10,
    PMT_PRE_16B = 2'b11
  } pmt_presc_t;

endpackage : pmt_pkg

// >>> hdl/pmt_event_div.sv
`timescale 1ns/1ps
module pmt_event_div
  import pmt_pkg::*;
#(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Control
  input wire logic clear,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  // Result
  output logic pulse,
  output logic [W-1:0] count
);

  // Suppressed on clear so a flushed divider never emits a stray event
  assign pulse = tick && !clear && (count == limit);

  always_ff @(posedge clk_sys) begin
    if (sys_rst || clear) begin
      count <= '0;
    end else if (tick) begin
      if (count >= limit) begin
        count <= '0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  a_div_wrap: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pulse |=> count == '0)
    else $error("divider did not wrap after its event");

endmodule : pmt_event_div

// >>> hdl/pmt_timer.sv
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "pmt_defines.svh"
module pmt_timer
  import pmt_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Time base outputs
  output logic periodMatch,
  output logic postscaleEvent,
  output logic matchFlag
);

  ////////////////////////////////////////////////////////////
  // Register state
  pmt_byte_t count;
  pmt_byte_t period;
  logic [3:0] postSel;
  logic runEn;
  pmt_presc_t preSel;

  // Bus pipeline
  logic take;
  logic [7:0] dAddr;
  logic dWrite;
  logic rdWait;
  logic wrCount;
  logic wrPeriod;
  logic wrControl;
  logic wrFlag;
  logic flagClr;
  logic divClr;
  pmt_byte_t rdMux;

  // Dividers
  logic quarterTick;
  logic preTick;
  logic [3:0] preLimit;
  logic [3:0] preCount;
  logic [3:0] postCount;
  logic atPeriod;

  ////////////////////////////////////////////////////////////
  // AHB-Lite front end
  assign take = hsel && htrans[1] && hready;
  // Reads take one wait state so read data always comes from a flop
  assign hreadyout = !rdWait;
  assign hresp = 1'b0;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dAddr <= 8'h00;
      dWrite <= 1'b0;
      rdWait <= 1'b0;
    end else begin
      dWrite <= take && hwrite;
      rdWait <= take && !hwrite;
      if (take) begin
        dAddr <= haddr;
      end
    end
  end

  // Writes land at the end of their single data-phase cycle
  assign wrCount = dWrite && (dAddr == `PMT_OFF_COUNT);
  assign wrPeriod = dWrite && (dAddr == `PMT_OFF_PERIOD);
  assign wrControl = dWrite && (dAddr == `PMT_OFF_CONTROL);
  assign wrFlag = dWrite && (dAddr == `PMT_OFF_FLAG);
  assign flagClr = wrFlag && hwdata[`PMT_FLAG_BIT];
  assign divClr = wrCount || wrControl;

  always_comb begin
    rdMux = 8'h00;
    case (dAddr)
      `PMT_OFF_COUNT: rdMux = count;
      `PMT_OFF_PERIOD: rdMux = period;
      `PMT_OFF_CONTROL: rdMux = {1'b0, postSel, runEn, preSel};
      `PMT_OFF_FLAG: rdMux = {7'h00, matchFlag};
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rdWait) begin
      hrdata <= {24'h00_0000, rdMux};
    end
  end

  ////////////////////////////////////////////////////////////
  // Period and control registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      period <= `PMT_RST_PERIOD;
    end else if (wrPeriod) begin
      period <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      postSel <= 4'h0;
      runEn <= 1'b0;
      preSel <= PMT_PRE_1;
    end else if (wrControl) begin
      postSel <= hwdata[`PMT_CTL_POST_HI:`PMT_CTL_POST_LO];
      runEn <= hwdata[`PMT_CTL_RUN];
      preSel <= pmt_presc_t'(hwdata[`PMT_CTL_PRE_HI:`PMT_CTL_PRE_LO]);
    end
  end

  ////////////////////////////////////////////////////////////
  // Clock over four, then prescaler
  pmt_event_div #(.W(4)) uQuarter (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clear(1'b0),
    .tick(1'b1),
    .limit(`PMT_QUARTER_LIMIT),
    .pulse(quarterTick),
    .count()
  );

  always_comb begin
    case (preSel)
      PMT_PRE_1: preLimit = `PMT_PRE1_LIMIT;
      PMT_PRE_4: preLimit = `PMT_PRE4_LIMIT;
      default: preLimit = `PMT_PRE16_LIMIT;
    endcase
  end

  // Off means no ticks reach the prescaler or count; only the clock-over-four divider keeps toggling
  pmt_event_div #(.W(4)) uPre (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clear(divClr),
    .tick(quarterTick && runEn),
    .limit(preLimit),
    .pulse(preTick),
    .count(preCount)
  );

  ////////////////////////////////////////////////////////////
  // Count register and period match
  assign atPeriod = (count == period);
  // Match is the step that takes count back to zero
  assign periodMatch = preTick && atPeriod && !wrCount;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count <= `PMT_RST_COUNT;
    end else if (wrCount) begin
      count <= hwdata[7:0];
    end else if (preTick) begin
      if (atPeriod) begin
        count <= 8'h00;
      end else begin
        count <= count + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Postscaler and flag
  pmt_event_div #(.W(4)) uPost (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clear(divClr),
    .tick(periodMatch),
    .limit(postSel),
    .pulse(postscaleEvent),
    .count(postCount)
  );

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      matchFlag <= 1'b0;
    end else if (postscaleEvent) begin
      matchFlag <= 1'b1;
    end else if (flagClr) begin
      matchFlag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // Checks
  sequence s_step_due;
    preTick && !wrCount;
  endsequence

  sequence s_read_taken;
    take && !hwrite;
  endsequence

  a_count_wrap: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_step_due and atPeriod |=> count == 8'h00)
    else $error("count did not wrap at period");

  a_count_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_step_due and !atPeriod |=> count == $past(count) + 8'h01)
    else $error("count did not step by one");

  a_period_reset: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(sys_rst) |-> period == 8'hff && count == 8'h00)
    else $error("reset values wrong");

  a_pre_direct: assert property (@(posedge clk_sys) disable iff (sys_rst)
    preSel == PMT_PRE_1 && runEn && !divClr |-> preTick == quarterTick)
    else $error("divide by one prescale wrong");

  a_pre_sixteen: assert property (@(posedge clk_sys) disable iff (sys_rst)
    preTick && preSel[1] |-> preCount == 4'hf)
    else $error("divide by sixteen prescale wrong");

  a_post_select: assert property (@(posedge clk_sys) disable iff (sys_rst)
    postscaleEvent |-> periodMatch && postCount == postSel)
    else $error("postscale event at wrong match");

  a_flag_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    postscaleEvent |=> matchFlag)
    else $error("flag not set by event");

  a_div_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    divClr |=> preCount == 4'h0 && postCount == 4'h0)
    else $error("dividers not cleared by write");

  a_ctrl_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wrControl |=> $stable(count))
    else $error("control write moved count");

  a_stop_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !runEn && !wrCount |=> $stable(count))
    else $error("count moved while off");

  a_ctrl_bit7: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rdWait && dAddr == `PMT_OFF_CONTROL |=> hrdata[7] == 1'b0)
    else $error("control bit 7 not zero");

  a_period_rdbk: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_read_taken ##1 (dAddr == `PMT_OFF_PERIOD) |=> hrdata[7:0] == $past(period))
    else $error("period readback wrong");

  a_match_out: assert property (@(posedge clk_sys) disable iff (sys_rst)
    periodMatch |=> count == 8'h00)
    else $error("match without wrap");

  a_flag_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
    matchFlag && !flagClr |=> matchFlag)
    else $error("flag dropped without clear");

  a_read_wait: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_read_taken |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  sequence s_write_taken;
    take && hwrite;
  endsequence

  // Quarter tick comes once in every four clocks
  sequence s_quarter_gap;
    (!quarterTick) [*3] ##1 quarterTick;
  endsequence

  a_quarter_rate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    quarterTick |=> s_quarter_gap)
    else $error("quarter tick spacing wrong");

  a_pre_four: assert property (@(posedge clk_sys) disable iff (sys_rst)
    preTick && preSel == PMT_PRE_4 |-> preCount == 4'h3)
    else $error("divide by four prescale wrong");

  a_count_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_write_taken ##1 wrCount |=> count == $past(hwdata[7:0]))
    else $error("count write did not land");

  // Count moves only on a step or a write
  a_count_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !preTick && !wrCount |=> $stable(count))
    else $error("count moved without a step");

  a_period_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_write_taken ##1 wrPeriod |=> period == $past(hwdata[7:0]))
    else $error("period write did not land");

  a_period_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !wrPeriod |=> $stable(period))
    else $error("period moved without a write");

  a_ctrl_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wrControl |=> postSel == $past(hwdata[`PMT_CTL_POST_HI:`PMT_CTL_POST_LO])
      && runEn == $past(hwdata[`PMT_CTL_RUN]) && preSel == $past(hwdata[`PMT_CTL_PRE_HI:`PMT_CTL_PRE_LO]))
    else $error("control write did not land");

  a_stop_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !runEn |-> !preTick && !periodMatch)
    else $error("step while timer off");

  a_match_single: assert property (@(posedge clk_sys) disable iff (sys_rst)
    periodMatch |=> !periodMatch)
    else $error("match pulse longer than one cycle");

  a_post_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !periodMatch && !divClr |=> $stable(postCount))
    else $error("postscaler moved without a match");

  // Set wins, so a clear only shows when no event is due
  a_flag_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    flagClr && !postscaleEvent |=> !matchFlag)
    else $error("flag not cleared by write");

  a_flag_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !matchFlag && !postscaleEvent |=> !matchFlag)
    else $error("flag set without an event");

  a_write_ready: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_write_taken |=> hreadyout)
    else $error("write data phase stalled");

  a_rdata_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !rdWait |=> $stable(hrdata))
    else $error("read data changed outside a read");

  a_rdata_upper: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rdWait |=> hrdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  a_unmapped_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rdWait && !(dAddr inside {`PMT_OFF_COUNT, `PMT_OFF_PERIOD, `PMT_OFF_CONTROL, `PMT_OFF_FLAG})
      |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");

endmodule : pmt_timer

// >>> tb/test_pmt_timer.sv
`timescale 1ns/1ps
`include "pmt_defines.svh"
module test_pmt_timer;
  import pmt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, reset and bus signals
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic periodMatch;
  logic postscaleEvent;
  logic matchFlag;
  int nMismatch = 0;
  int totalChecks = 0;
  int cycles = 0;
  int gap;

  always #50 clk_sys = ~clk_sys;

  pmt_timer dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .periodMatch(periodMatch),
    .postscaleEvent(postscaleEvent), .matchFlag(matchFlag)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Closing report, also reached when a hang is cut short
  task end_sim;
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // Ceiling is several times the expected run length
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      nMismatch = nMismatch + 1;
      end_sim();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks = totalChecks + 1;
    if (got !== exp) begin
      nMismatch = nMismatch + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////////
  // Single AHB-Lite word transfer; waits on hready in both phases
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
    hsel <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] junk;
    xfer(1'b1, a, {24'h0, d}, junk);
  endtask : wr

  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, {24'h0, exp});
  endtask : rdchk

  // Cycles until the chosen pulse is seen, bounded
  task waitEv(input logic post, output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      n = n + 1;
    end while (((post ? postscaleEvent : periodMatch) !== 1'b1) && n < 3000);
  endtask : waitEv

  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rdchk(`PMT_OFF_COUNT, 8'h00);
    rdchk(`PMT_OFF_PERIOD, 8'hff);
    rdchk(`PMT_OFF_CONTROL, 8'h00);
    rdchk(`PMT_OFF_FLAG, 8'h00);
    rdchk(8'h10, 8'h00);
    chk({31'h0, hresp}, 32'h0);
    $display("test reset_values done");

    wr(`PMT_OFF_PERIOD, 8'h5a);
    rdchk(`PMT_OFF_PERIOD, 8'h5a);
    wr(`PMT_OFF_COUNT, 8'h40);
    rdchk(`PMT_OFF_COUNT, 8'h40);
    wr(`PMT_OFF_CONTROL, 8'hfb);
    rdchk(`PMT_OFF_CONTROL, 8'h7b);
    rdchk(`PMT_OFF_COUNT, 8'h40);
    repeat (100) @(posedge clk_sys);
    rdchk(`PMT_OFF_COUNT, 8'h40);
    wr(8'h10, 8'h77);
    rdchk(8'h10, 8'h00);
    $display("test register_access done");

    // Match spacing for each prescale code; period 3 gives four steps
    wr(`PMT_OFF_PERIOD, 8'h03);
    for (int p = 0; p < 4; p++) begin
      wr(`PMT_OFF_CONTROL, {5'h0, 1'b1, p[1:0]});
      waitEv(1'b0, gap);
      waitEv(1'b0, gap);
      chk(gap, 16 << (2 * ((p > 2) ? 2 : p)));
      if (p >= 2) begin
        rdchk(`PMT_OFF_COUNT, 8'h00);
      end
    end
    $display("test prescale done");

    // Period 0 matches every step; every postscale code
    wr(`PMT_OFF_PERIOD, 8'h00);
    for (int s = 0; s < 16; s++) begin
      wr(`PMT_OFF_CONTROL, {1'b0, s[3:0], 1'b1, 2'b00});
      waitEv(1'b1, gap);
      waitEv(1'b1, gap);
      chk(gap, 4 * (s + 1));
    end
    $display("test postscale done");

    // Flag sticks with the timer stopped and clears on a write of one
    @(posedge clk_sys);
    chk({31'h0, matchFlag}, 32'h1);
    wr(`PMT_OFF_CONTROL, 8'h00);
    repeat (50) @(posedge clk_sys);
    rdchk(`PMT_OFF_FLAG, 8'h01);
    wr(`PMT_OFF_FLAG, 8'h01);
    rdchk(`PMT_OFF_FLAG, 8'h00);
    chk({31'h0, matchFlag}, 32'h0);
    $display("test flag done");

    // A count write restarts the prescaler, so the next step is 61 to 64 cycles away
    wr(`PMT_OFF_PERIOD, 8'h05);
    wr(`PMT_OFF_CONTROL, 8'h06);
    repeat (37) @(posedge clk_sys);
    wr(`PMT_OFF_COUNT, 8'h05);
    waitEv(1'b0, gap);
    chk(32'(gap >= 58 && gap <= 66), 32'h1);
    rdchk(`PMT_OFF_FLAG, 8'h01);
    $display("test prescaler_clear done");

    // Reset in mid-run brings count, period and control back
    wr(`PMT_OFF_COUNT, 8'h02);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rdchk(`PMT_OFF_COUNT, 8'h00);
    rdchk(`PMT_OFF_PERIOD, 8'hff);
    rdchk(`PMT_OFF_CONTROL, 8'h00);
    $display("test mid_reset done");
    end_sim();
  end

endmodule : test_pmt_timer
